// file: src/btc_params.svh
// Purpose: constants for the carry flag timer (offsets, fields, resets, times)
// Assumes: 100 MHz reference clock
// Notes:   times are in microseconds; cycle counts are derived in the top
`ifndef BTC_PARAMS_SVH
`define BTC_PARAMS_SVH

`define BTC_RF_ADDR_W          7
`define BTC_RF_DATA_W          4
`define BTC_ADDR_INTERVAL_SEL  7'h09
`define BTC_ADDR_CARRY_JUDGE   7'h17
`define BTC_CARRY_SEL_LO_BIT   0
`define BTC_CARRY_SEL_HI_BIT   1
`define BTC_BT1_SEL_LO_BIT     2
`define BTC_BT1_SEL_HI_BIT     3
`define BTC_CARRY_FLAG_BIT     0
`define BTC_INTERVAL_SEL_RST   4'h0
`define BTC_CARRY_JUDGE_RST    4'h0
`define BTC_CLK_MHZ            100
`define BTC_T_1KHZ_US          1000
`define BTC_T_200HZ_US         5000
`define BTC_T_10HZ_US          100000
`define BTC_T_4HZ_US           250000

`endif

// file: src/btc_pkg.sv
// Purpose: types shared by the carry flag timer
// Assumes: btc_params.svh holds every width; the selection and CE state codes are set here
// Notes:   none
`include "btc_params.svh"

package btc_pkg;

  // one register file access from the processor core
  typedef struct packed {
    logic [`BTC_RF_ADDR_W-1:0] addr;
    logic                      rd;
    logic                      wr;
    logic [`BTC_RF_DATA_W-1:0] wdata;
  } btc_rf_req_t;

  // selection codes in the low two bits of the interval select register
  typedef enum logic [1:0] {
    BTC_SEL_4HZ   = 2'h0,
    BTC_SEL_10HZ  = 2'h1,
    BTC_SEL_200HZ = 2'h2,
    BTC_SEL_1KHZ  = 2'h3
  } btc_sel_e;

  typedef enum logic [1:0] {
    BTC_CE_IDLE = 2'h1,
    BTC_CE_WAIT = 2'h2
  } btc_ce_state_e;

endpackage

// file: src/btc_pulse_divider.sv
// Purpose: four free-running square-wave setting pulses from the ref clock
// Assumes: half periods given in reference clock cycles
// Notes:   the pulses run free and resync only on srst_i, so a selection change is glitchy
`include "btc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module btc_pulse_divider #(
  parameter int unsigned HALF_CYC [4] = '{2, 2, 2, 2}
) (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  output var  logic [3:0] pulse_o
);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_div
      logic [31:0] cnt;
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          cnt        <= 32'h0;
          pulse_o[g] <= 1'b0;
        end else if (cnt >= HALF_CYC[g] - 1) begin
          cnt        <= 32'h0;
          pulse_o[g] <= ~pulse_o[g];
        end else begin
          cnt <= cnt + 32'h1;
        end
      end
    end
  endgenerate

endmodule // btc_pulse_divider

`default_nettype wire

// file: src/btc_carry_timer.sv
// Purpose: carry flag timer with read-and-clear flag and CE reset sync
// Assumes: register file reads and writes arrive as one-cycle strobes
// Notes:   srst_i is the power-on reset; clock stop reset is a separate pulse
`include "btc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module btc_carry_timer
  import btc_pkg::*;
#(
  parameter int unsigned CYC_1KHZ  = `BTC_T_1KHZ_US * `BTC_CLK_MHZ,
  parameter int unsigned CYC_200HZ = `BTC_T_200HZ_US * `BTC_CLK_MHZ,
  parameter int unsigned CYC_10HZ  = `BTC_T_10HZ_US * `BTC_CLK_MHZ,
  parameter int unsigned CYC_4HZ   = `BTC_T_4HZ_US * `BTC_CLK_MHZ
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      clk_stop_rst_i,
  input  wire logic                      ce_pin_i,
  input  wire logic [`BTC_RF_ADDR_W-1:0] rf_addr_i,
  input  wire logic                      rf_rd_i,
  input  wire logic                      rf_wr_i,
  input  wire logic [`BTC_RF_DATA_W-1:0] rf_wdata_i,
  output var  logic [`BTC_RF_DATA_W-1:0] rf_rdata_o,
  output var  logic                      carry_flag_o,
  output var  logic [1:0]                bt1_interval_sel_o,
  output var  logic                      ce_reset_o
);

  localparam int unsigned HALF_CYC [4] = '{
    CYC_4HZ / 2, CYC_10HZ / 2, CYC_200HZ / 2, CYC_1KHZ / 2
  };

  btc_rf_req_t                 req;
  logic [3:0]                  pulses;
  logic [`BTC_RF_DATA_W-1:0]   interval_select;
  btc_sel_e                    carry_sel;
  logic                        sel_pulse;
  logic                        sel_pulse_q;
  logic                        set_edge;
  logic                        carry_flag;
  logic                        set_armed;
  logic                        flag_read;
  logic                        sel_write;
  logic                        ce_q;
  logic                        ce_rise;
  logic                        ce_fire;
  btc_ce_state_e               ce_state;
  btc_ce_state_e               next_ce_state;

  assign req = '{addr: rf_addr_i, rd: rf_rd_i, wr: rf_wr_i,
                 wdata: rf_wdata_i};

  btc_pulse_divider #(
    .HALF_CYC (HALF_CYC)
  ) u_div (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pulse_o   (pulses)
  );

  assign flag_read = req.rd && (req.addr == `BTC_ADDR_CARRY_JUDGE);
  assign sel_write = req.wr && (req.addr == `BTC_ADDR_INTERVAL_SEL);

  // interval select: power-on and clock stop clear it, CE reset keeps it
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clk_stop_rst_i) begin
      interval_select <= `BTC_INTERVAL_SEL_RST;
    end else if (sel_write) begin
      interval_select <= req.wdata;
    end
  end

  assign carry_sel = btc_sel_e'(interval_select[`BTC_CARRY_SEL_HI_BIT:
                                                `BTC_CARRY_SEL_LO_BIT]);
  assign bt1_interval_sel_o = interval_select[`BTC_BT1_SEL_HI_BIT:
                                              `BTC_BT1_SEL_LO_BIT];

  always_comb begin
    unique case (carry_sel)
      BTC_SEL_4HZ:   sel_pulse = pulses[0];
      BTC_SEL_10HZ:  sel_pulse = pulses[1];
      BTC_SEL_200HZ: sel_pulse = pulses[2];
      BTC_SEL_1KHZ:  sel_pulse = pulses[3];
    endcase
  end

  // the history is the selector's output, not each pulse, so that a switch
  // onto a high pulse looks like a rising edge
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sel_pulse_q <= 1'b0;
    end else begin
      sel_pulse_q <= sel_pulse;
    end
  end

  assign set_edge = sel_pulse && !sel_pulse_q;

  // setting stays blocked after power-on until the flag is read once
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      set_armed <= 1'b0;
    end else if (flag_read) begin
      set_armed <= 1'b1;
    end
  end

  // one bit serves as both flip-flop and flag, so they cannot disagree
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      carry_flag <= 1'b0;
    end else if (clk_stop_rst_i || ce_fire) begin
      carry_flag <= 1'b1;
    end else if (set_edge && set_armed) begin
      carry_flag <= 1'b1;
    end else if (flag_read) begin
      carry_flag <= 1'b0;
    end
  end

  assign carry_flag_o = carry_flag;

  // read data is registered; writes to the judge register fall through
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rf_rdata_o <= `BTC_CARRY_JUDGE_RST;
    end else if (req.rd) begin
      if (req.addr == `BTC_ADDR_INTERVAL_SEL) begin
        rf_rdata_o <= interval_select;
      end else if (flag_read) begin
        rf_rdata_o <= {{(`BTC_RF_DATA_W-1){1'b0}}, carry_flag};
      end else begin
        rf_rdata_o <= '0;
      end
    end
  end
  // no write path touches carry_flag or set_armed

  // CE pin edge; the history starts high so a pin already high at power-on
  // does not trigger a reset by itself
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ce_q <= 1'b1;
    end else begin
      ce_q <= ce_pin_i;
    end
  end

  assign ce_rise = ce_pin_i && !ce_q;

  // sync point is the selected pulse edge even while setting is blocked;
  // a coinciding flag read defers the reset to the next edge
  assign ce_fire = (ce_state == BTC_CE_WAIT) && set_edge
                   && !flag_read;

  always_comb begin
    next_ce_state = ce_state;
    unique case (ce_state)
      BTC_CE_IDLE: if (ce_rise) next_ce_state = BTC_CE_WAIT;
      BTC_CE_WAIT: if (ce_fire) next_ce_state = BTC_CE_IDLE;
      default:     next_ce_state = BTC_CE_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clk_stop_rst_i) begin
      ce_state <= BTC_CE_IDLE;
    end else begin
      ce_state <= next_ce_state;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ce_reset_o <= 1'b0;
    end else begin
      ce_reset_o <= ce_fire;
    end
  end

endmodule // btc_carry_timer

`default_nettype wire

// file: test/btc_carry_timer_assertions.sv
// Purpose: port-level checks of the carry flag timer
// Assumes: srst_i is the power-on reset, one clock domain
// Notes:   bound from the bench top file
`include "btc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module btc_carry_timer_chk (
  input wire logic                      ref_clk_i,
  input wire logic                      srst_i,
  input wire logic                      clk_stop_rst_i,
  input wire logic                      ce_pin_i,
  input wire logic [`BTC_RF_ADDR_W-1:0] rf_addr_i,
  input wire logic                      rf_rd_i,
  input wire logic                      rf_wr_i,
  input wire logic [`BTC_RF_DATA_W-1:0] rf_wdata_i,
  input wire logic [`BTC_RF_DATA_W-1:0] rf_rdata_o,
  input wire logic                      carry_flag_o,
  input wire logic [1:0]                bt1_interval_sel_o,
  input wire logic                      ce_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic rd_cj;
  logic wr_cj;
  logic wr_sel;
  logic quiet;
  assign rd_cj  = rf_rd_i && rf_addr_i == `BTC_ADDR_CARRY_JUDGE;
  assign wr_cj  = rf_wr_i && rf_addr_i == `BTC_ADDR_CARRY_JUDGE;
  assign wr_sel = rf_wr_i && rf_addr_i == `BTC_ADDR_INTERVAL_SEL;
  // high from power-on until anything may legally set the flag
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !(rd_cj || clk_stop_rst_i || ce_reset_o))
      quiet <= srst_i ? 1'b1 : quiet;
    else
      quiet <= 1'b0;
  end
  a_read_returns: assert property (rd_cj |=>
    rf_rdata_o == {3'h0, $past(carry_flag_o)}) else $error("bad read");
  a_flag_stands: assert property (carry_flag_o && !rd_cj |=>
    carry_flag_o) else $error("flag lost");
  a_blocked_por: assert property (quiet && !ce_reset_o |->
    !carry_flag_o) else $error("set while blocked");
  a_first_read: assert property (quiet && !ce_reset_o && rd_cj |=>
    rf_rdata_o == 4'h0) else $error("first read not 0");
  a_ce_sets: assert property (ce_reset_o |-> carry_flag_o)
    else $error("ce left flag low");
  a_stop_sets: assert property (clk_stop_rst_i |=> carry_flag_o &&
    bt1_interval_sel_o == 2'h0) else $error("stop reset wrong");
  a_ce_pulse: assert property (ce_reset_o |=> !ce_reset_o)
    else $error("ce pulse long");
  a_read_defers: assert property (ce_reset_o |-> !$past(rd_cj))
    else $error("ce not deferred");
  a_sel_write: assert property (wr_sel && !clk_stop_rst_i |=>
    bt1_interval_sel_o == $past(rf_wdata_i[3:2])) else $error("bad sel");
  a_cj_inert: assert property (wr_cj && !clk_stop_rst_i |=>
    $stable(bt1_interval_sel_o)) else $error("write had effect");
endmodule // btc_carry_timer_chk
`default_nettype wire

// file: test/btc_carry_timer_tb_top.sv
// Purpose: directed bench for the carry flag timer
// Assumes: pulse periods shortened to 8/12/20/40 cycles
// Notes:   checker bound at the foot of this file
`include "btc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module btc_carry_timer_tb_top;
  int         per [4] = '{40, 20, 12, 8};
  logic       ref_clk_i = 0, srst_i = 1, clk_stop_rst_i = 0, ce_pin_i = 0;
  logic       rf_rd_i = 0, rf_wr_i = 0, carry_flag_o, ce_reset_o;
  logic [6:0] rf_addr_i = 7'h0;
  logic [3:0] rf_wdata_i = 4'h0, rf_rdata_o, got;
  logic [1:0] bt1_interval_sel_o;
  int         fails = 0, compares = 0, cyc = 0;
  btc_carry_timer #(.CYC_1KHZ(8), .CYC_200HZ(12), .CYC_10HZ(20),
    .CYC_4HZ(40)) dut_u (.ref_clk_i, .srst_i, .clk_stop_rst_i, .ce_pin_i,
    .rf_addr_i, .rf_rd_i, .rf_wr_i, .rf_wdata_i, .rf_rdata_o,
    .carry_flag_o, .bt1_interval_sel_o, .ce_reset_o);
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one register access; rd low means a write
  task automatic acc(input logic [6:0] a, input logic rd, input logic [3:0] d);
    @(posedge ref_clk_i);
    rf_addr_i <= a;
    rf_rd_i <= rd;
    rf_wr_i <= !rd;
    rf_wdata_i <= d;
    @(posedge ref_clk_i);
    rf_rd_i <= 0;
    rf_wr_i <= 0;
    #1 got = rf_rdata_o;
  endtask
  // clear a stale flag first so t marks a genuine set
  task automatic wait_rise(output int t);
    int n;
    n = 0;
    while (carry_flag_o === 1'b1 && n < 4) begin
      acc(`BTC_ADDR_CARRY_JUDGE, 1, 4'h0);
      n++;
    end
    while (carry_flag_o !== 1'b1 && n < 200) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    t = cyc;
    chk({3'h0, carry_flag_o}, 4'h1);
  endtask
  task automatic do_reset();
    @(posedge ref_clk_i);
    srst_i <= 1;
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 0;
  endtask
  task automatic s_power_on();
    repeat (90) @(posedge ref_clk_i);
    #1 chk({3'h0, carry_flag_o}, 4'h0);
    acc(`BTC_ADDR_CARRY_JUDGE, 1, 4'h0);
    chk(got, 4'h0);
  endtask
  task automatic s_periods();
    int t1, t2;
    for (int i = 0; i < 4; i++) begin
      acc(`BTC_ADDR_INTERVAL_SEL, 0, {2'(3 - i), 2'(i)});
      chk({2'h0, bt1_interval_sel_o}, 4'(3 - i));
      // a switch onto a high pulse sets the flag off-period; skip that set
      wait_rise(t1);
      wait_rise(t1);
      acc(`BTC_ADDR_CARRY_JUDGE, 0, 4'h0);
      chk({3'h0, carry_flag_o}, 4'h1);
      acc(`BTC_ADDR_CARRY_JUDGE, 1, 4'h0);
      chk(got, 4'h1);
      chk({3'h0, carry_flag_o}, 4'h0);
      wait_rise(t2);
      chk({3'h0, (t2 - t1) == per[i]}, 4'h1);
    end
  endtask
  // read lands on the first set point after the pin rises
  task automatic s_ce_reset();
    int t, n;
    acc(`BTC_ADDR_INTERVAL_SEL, 0, 4'h7);
    wait_rise(t);
    @(posedge ref_clk_i);
    ce_pin_i <= 1;
    repeat (5) @(posedge ref_clk_i);
    acc(`BTC_ADDR_CARRY_JUDGE, 1, 4'h0);
    n = 0;
    while (ce_reset_o !== 1'b1 && n < 40) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    chk({3'h0, n == 8}, 4'h1);
    chk({3'h0, carry_flag_o}, 4'h1);
    ce_pin_i <= 0;
    acc(`BTC_ADDR_INTERVAL_SEL, 1, 4'h0);
    chk(got, 4'h7);
  endtask
  task automatic s_clock_stop();
    acc(`BTC_ADDR_CARRY_JUDGE, 1, 4'h0);
    @(posedge ref_clk_i);
    clk_stop_rst_i <= 1;
    @(posedge ref_clk_i);
    clk_stop_rst_i <= 0;
    #1 chk({3'h0, carry_flag_o}, 4'h1);
    acc(`BTC_ADDR_INTERVAL_SEL, 1, 4'h0);
    chk(got, 4'h0);
    acc(7'h7f, 1, 4'h0);
    chk(got, 4'h0);
  endtask
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    do_reset();
    s_power_on();
    s_periods();
    s_ce_reset();
    s_clock_stop();
    do_reset();
    s_power_on();
    give_verdict();
  end
endmodule // btc_carry_timer_tb_top
bind btc_carry_timer btc_carry_timer_chk chk_u (.ref_clk_i, .srst_i,
  .clk_stop_rst_i, .ce_pin_i, .rf_addr_i, .rf_rd_i, .rf_wr_i, .rf_wdata_i,
  .rf_rdata_o, .carry_flag_o, .bt1_interval_sel_o, .ce_reset_o);
`default_nettype wire
